//--- ppsp_pkg.sv
package ppsp_pkg;
   // Register word offsets (byte addresses)
   localparam logic [3:0] PPSP_CONTROL_OFS = 4'h0;
   localparam logic [3:0] PPSP_MODE_OFS    = 4'h4;
   localparam logic [3:0] PPSP_STROBE_OFS  = 4'h8;
   localparam logic [3:0] PPSP_PINCFG_OFS  = 4'hC;

   // Control and mode register field positions
   localparam int PPSP_WREN_BIT  = 9;
   localparam int PPSP_RDEN_BIT  = 8;
   localparam int PPSP_CSF_HI    = 7;
   localparam int PPSP_CSF_LO    = 6;
   localparam int PPSP_ALP_BIT   = 5;
   localparam int PPSP_CHIP_SELECT_ONE_POLARITY_BIT  = 3;
   localparam int PPSP_BEP_BIT   = 2;
   localparam int PPSP_WRITE_STROBE_POLARITY_BIT  = 1;
   localparam int PPSP_READ_STROBE_POLARITY_BIT  = 0;
   localparam int PPSP_MODE_LO   = 8;

   // Writable bits of the control register; bit 4 and 14 read zero
   localparam logic [15:0] PPSP_CONTROL_MASK = 16'hBFEF;
   localparam logic [15:0] PPSP_CONTROL_RST  = 16'h0000;
   localparam logic [15:0] PPSP_MODE_RST     = 16'h0000;
   localparam logic [1:0]  PPSP_CSF_CHIPSEL  = 2'h2;
   localparam logic [1:0]  PPSP_MODE_MASTER1 = 2'h3;

   // Raw (active-high) strobe requests from the port engine
   typedef struct packed {
      logic addrLatch;
      logic chipSel;
      logic byteEn;
      logic write;
      logic read;
      logic enable;
      logic readWrite;
   } ppsp_strobe_t;

   // Pin-side levels and enables
   typedef struct packed {
      logic addrLatchPin;
      logic chipSelPin;
      logic byteEnPin;
      logic wrPin;
      logic rdPin;
      logic wrOe;
      logic rdOe;
   } ppsp_pins_t;
endpackage

//--- ppsp_strobe_polarity.sv
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Write/enable strobe pin released when its pin-enable bit is zero.
// - Chip-select pin acts as chip select only for function code 10.
// - Bit 5 sets address latch strobe level, high when set.
// - Bit 2 sets byte-enable level, high when set.
// - Separate-strobe modes: bit 1 sets write strobe level.
// - Master mode 1: bit 1 sets enable strobe level.
// - Separate-strobe modes: bit 0 sets read strobe level.
// - Master mode 1: bit 0 sets read/write strobe level.
// - Latch and chip-select polarity ignored on pins used as address.
module ppsp_strobe_polarity
   import ppsp_pkg::*;
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // Wishbone slave
   input  wire logic [3:0]          wbAdr,
   input  wire logic [31:0]         wbDatI,
   output logic      [31:0]         wbDatO,
   input  wire logic [3:0]          wbSel,
   input  wire logic                wbWe,
   input  wire logic                wbCyc,
   input  wire logic                wbStb,
   output logic                     wbAck,
   output logic                     wbErr,
   // Strobe requests from port engine
   input  wire ppsp_pkg::ppsp_strobe_t strobeReq,
   // Address-line use of latch and chip-select pins
   input  wire logic                latchIsAddr,
   input  wire logic                chipSelIsAddr,
   input  wire logic                latchAddrBit,
   input  wire logic                chipSelAddrBit,
   // Pins
   output ppsp_pkg::ppsp_pins_t     pins
);
   import ppsp_pkg::*;

   logic [15:0]  controlReg_r;
   logic [15:0]  controlReg_nxt;
   logic [15:0]  modeReg_r;
   logic [15:0]  modeReg_nxt;
   logic         ack_r;
   logic         err_r;
   logic [31:0]  rdData_r;
   ppsp_pins_t   pins_r;
   ppsp_pins_t   pins_nxt;

   wire          busReq    = wbCyc && wbStb && !ack_r && !err_r;
   wire          selCtrl   = (wbAdr == PPSP_CONTROL_OFS);
   wire          selMode   = (wbAdr == PPSP_MODE_OFS);
   wire          selStrobe = (wbAdr == PPSP_STROBE_OFS);
   wire          selPins   = (wbAdr == PPSP_PINCFG_OFS);
   wire          mapped    = selCtrl | selMode | selStrobe | selPins;
   wire          wrCtrl    = busReq && wbWe && selCtrl;
   wire          wrMode    = busReq && wbWe && selMode;
   wire [15:0]   laneMask  = {{8{wbSel[1]}}, {8{wbSel[0]}}};

   // Unimplemented control bits masked; the mode register keeps all 16 bits
   // bits four and fourteen dropped
   assign controlReg_nxt = wrCtrl
      ? ((controlReg_r & ~laneMask) | (wbDatI[15:0] & laneMask))
        & PPSP_CONTROL_MASK
      : controlReg_r;
   assign modeReg_nxt = wrMode
      ? (modeReg_r & ~laneMask) | (wbDatI[15:0] & laneMask)
      : modeReg_r;

   wire [1:0] portMode = modeReg_r[PPSP_MODE_LO +: 2];
   wire       master1  = (portMode == PPSP_MODE_MASTER1);
   wire [1:0] csFunc   = controlReg_r[PPSP_CSF_HI:PPSP_CSF_LO];

   wire latchLvl = latchIsAddr ? latchAddrBit
      : ~(strobeReq.addrLatch ^ controlReg_r[PPSP_ALP_BIT]);
   // only code 10 gives chip select
   wire csActive = (csFunc == PPSP_CSF_CHIPSEL) && strobeReq.chipSel;
   wire csLvl = chipSelIsAddr ? chipSelAddrBit
      : ~(csActive ^ controlReg_r[PPSP_CHIP_SELECT_ONE_POLARITY_BIT]);
   wire beLvl = ~(strobeReq.byteEn ^ controlReg_r[PPSP_BEP_BIT]);
   // enable strobe in master mode 1
   wire wrRaw = master1 ? strobeReq.enable : strobeReq.write;
   wire wrLvl = ~(wrRaw ^ controlReg_r[PPSP_WRITE_STROBE_POLARITY_BIT]);
   // read/write strobe in master mode 1
   wire rdRaw = master1 ? strobeReq.readWrite : strobeReq.read;
   wire rdLvl = ~(rdRaw ^ controlReg_r[PPSP_READ_STROBE_POLARITY_BIT]);

   always_comb begin
      pins_nxt.addrLatchPin = latchLvl;
      pins_nxt.chipSelPin   = csLvl;
      pins_nxt.byteEnPin    = beLvl;
      pins_nxt.wrPin        = wrLvl;
      pins_nxt.rdPin        = rdLvl;
      pins_nxt.wrOe         = controlReg_r[PPSP_WREN_BIT];
      pins_nxt.rdOe         = controlReg_r[PPSP_RDEN_BIT];
   end

   // Status words let software see live strobes and pin levels
   wire [31:0] rdMux =
        selCtrl   ? {16'h0000, controlReg_r}
      : selMode   ? {16'h0000, modeReg_r}
      : selStrobe ? {25'h0000000, strobeReq}
      : selPins   ? {25'h0000000, pins_r}
      : 32'h00000000;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         controlReg_r <= PPSP_CONTROL_RST;
         modeReg_r    <= PPSP_MODE_RST;
         ack_r        <= 1'b0;
         err_r        <= 1'b0;
         rdData_r     <= 32'h00000000;
         pins_r       <= '0;
      end else begin
         controlReg_r <= controlReg_nxt;
         modeReg_r    <= modeReg_nxt;
         ack_r        <= busReq && mapped;
         err_r        <= busReq && !mapped;
         rdData_r     <= busReq ? rdMux : rdData_r;
         pins_r       <= pins_nxt;
      end
   end

   assign wbAck  = ack_r;
   assign wbErr  = err_r;
   assign wbDatO = rdData_r;
   assign pins   = pins_r;
endmodule // ppsp_strobe_polarity
`default_nettype wire

//--- ppsp_strobe_polarity_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ppsp_strobe_polarity_asserts
   import ppsp_pkg::*;
(
   // Bus
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [3:0]  wbAdr,
   input wire logic [31:0] wbDatI,
   input wire logic        wbWe,
   input wire logic        wbAck,
   // Port
   input wire ppsp_pkg::ppsp_strobe_t strobeReq,
   input wire logic        latchIsAddr,
   input wire logic        latchAddrBit,
   input wire ppsp_pkg::ppsp_pins_t   pins
);
   // Shadows lag one edge, like the pin register
   logic [15:0]  c_r;
   logic [15:0]  md_r;
   ppsp_strobe_t rq_r;
   logic         lv_r;
   wire logic w = wbAck & wbWe;
   wire logic m1 = md_r[9:8] == PPSP_MODE_MASTER1;
   always_ff @(posedge clock) begin
      lv_r <= rst_n;
      rq_r <= strobeReq;
      if (!rst_n) c_r <= '0;
      else if (w && wbAdr == PPSP_CONTROL_OFS) c_r <= wbDatI[15:0];
      if (!rst_n) md_r <= '0;
      else if (w && wbAdr == PPSP_MODE_OFS) md_r <= wbDatI[15:0];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_oe; lv_r |-> pins.wrOe == c_r[9]; endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_csr; lv_r && c_r[7:6] != 2'h2 |-> pins.chipSelPin != c_r[3];
   endproperty
   a_csr: assert property (p_csr) else $error("cs off");
   property p_cs; lv_r && c_r[7:6] == 2'h2 |->
      pins.chipSelPin == (rq_r.chipSel ~^ c_r[3]); endproperty
   a_cs: assert property (p_cs) else $error("cs");
   property p_al; lv_r && !$past(latchIsAddr) |->
      pins.addrLatchPin == (rq_r.addrLatch ~^ c_r[5]); endproperty
   a_al: assert property (p_al) else $error("al");
   property p_la; latchIsAddr |=> pins.addrLatchPin == $past(latchAddrBit);
   endproperty
   a_la: assert property (p_la) else $error("la");
   property p_be; lv_r |-> pins.byteEnPin == (rq_r.byteEn ~^ c_r[2]);
   endproperty
   a_be: assert property (p_be) else $error("be");
   property p_wr; lv_r |->
      pins.wrPin == ((m1 ? rq_r.enable : rq_r.write) ~^ c_r[1]); endproperty
   a_wr: assert property (p_wr) else $error("wr");
   property p_rd; lv_r |->
      pins.rdPin == ((m1 ? rq_r.readWrite : rq_r.read) ~^ c_r[0]); endproperty
   a_rd: assert property (p_rd) else $error("rd");
endmodule // ppsp_strobe_polarity_asserts
bind ppsp_strobe_polarity ppsp_strobe_polarity_asserts uChk (
   .clock(clock), .rst_n(rst_n), .wbAdr(wbAdr), .wbDatI(wbDatI),
   .wbWe(wbWe), .wbAck(wbAck), .strobeReq(strobeReq), .pins(pins),
   .latchIsAddr(latchIsAddr), .latchAddrBit(latchAddrBit));
`default_nettype wire

//--- ppsp_periph_model.sv
`timescale 1ns/1ns
`default_nettype none
module ppsp_periph_model
   import ppsp_pkg::*;
(
   // Pins and resolved wire
   input wire ppsp_pkg::ppsp_pins_t pins,
   output logic                     wrWire
);
   // Released strobe floats to the pull-up
   assign wrWire = pins.wrOe ? pins.wrPin : 1'h1;
endmodule // ppsp_periph_model
`default_nettype wire

//--- ppsp_strobe_polarity_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin badCount++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module ppsp_strobe_polarity_tb_top;
   import ppsp_pkg::*;
   logic clock = 1'h0, rst_n = 1'h0, wbWe = 1'h0, wbCyc = 1'h0;
   logic wbStb = 1'h0, latchIsAddr = 1'h0, wbAck, wbErr, wrWire, rErr;
   logic latchAddrBit = 1'h0;
   logic [3:0] wbAdr = 4'h0;
   logic [31:0] wbDatI = 32'h0, wbDatO;
   logic [15:0] rDat;
   ppsp_strobe_t req = '0;
   ppsp_pins_t pins, expP;
   int badCount = 0, numChecks = 0;
   ppsp_strobe_polarity dut (.clock(clock), .rst_n(rst_n), .wbAdr(wbAdr),
      .wbDatI(wbDatI), .wbDatO(wbDatO), .wbSel(4'hF), .wbWe(wbWe),
      .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .wbErr(wbErr),
      .strobeReq(req), .latchIsAddr(latchIsAddr), .chipSelIsAddr(1'h0),
      .latchAddrBit(latchAddrBit), .chipSelAddrBit(1'h0), .pins(pins));
   ppsp_periph_model partner (.pins(pins), .wrWire(wrWire));
   task automatic bus(input logic [3:0] a, input logic w, input logic [15:0] d);
      wbAdr <= a;
      wbWe <= w;
      wbDatI <= {16'h0000, d};
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      // Only the watchdog ends a hung wait
      do @(posedge clock); while (wbAck !== 1'h1 && wbErr !== 1'h1);
      rDat = wbDatO[15:0];
      rErr = wbErr;
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
      @(posedge clock);
   endtask
   task automatic t_pol;
      ppsp_strobe_t r;
      logic q;
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            q = p[0];
            r = q ? 7'h29 : 7'h56;
            req <= r;
            bus(PPSP_MODE_OFS, 1'h1, {6'h00, m[1:0], 8'h00});
            bus(PPSP_CONTROL_OFS, 1'h1, q ? 16'h03AF : 16'h0380);
            expP = {r.addrLatch ~^ q, r.chipSel ~^ q, r.byteEn ~^ q,
               (m == 3 ? r.enable : r.write) ~^ q,
               (m == 3 ? r.readWrite : r.read) ~^ q, 2'h3};
            `CHK("pins", expP, pins)
         end
      end
   endtask
   task automatic t_misc;
      bus(PPSP_CONTROL_OFS, 1'h1, 16'hFFFF);
      bus(PPSP_CONTROL_OFS, 1'h0, 16'h0000);
      `CHK("control", 16'hBFEF, rDat)
      // All strobes asserted so a driven pin would differ from the released one
      req <= '1;
      bus(PPSP_CONTROL_OFS, 1'h1, 16'h0108);
      latchIsAddr <= 1'h1;
      latchAddrBit <= 1'h1;
      repeat (2) @(posedge clock);
      `CHK("chipsel", 1'h0, pins.chipSelPin)
      `CHK("latch", 1'h1, pins.addrLatchPin)
      `CHK("wrpin", 1'h0, pins.wrPin)
      `CHK("wroe", 1'h0, pins.wrOe)
      `CHK("wrwire", 1'h1, wrWire)
      bus(4'h2, 1'h1, 16'hFFFF);
      `CHK("err", 1'h1, rErr)
   endtask
   task automatic stop_test;
      if (badCount == 0 && numChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial forever #20 clock = ~clock;
   initial begin
      repeat (3000) @(posedge clock);
      badCount++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'h1;
      repeat (2) @(posedge clock);
      `CHK("reset pins", 7'h7C, pins)
      t_pol();
      t_misc();
      stop_test();
   end
endmodule // ppsp_strobe_polarity_tb_top
`default_nettype wire
